// ### logic/cfg_pins_defs.svh
/*
 Timing counts, widths and encodings of the configuration pin controller.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef CFG_PINS_DEFS_SVH
`define CFG_PINS_DEFS_SVH

`define MODE_W        4
`define PLL_PINS      16
`define CLEAR_CYCLES  8'h10
`define CLEAR_W       8
`define FRAME_W       16
`define FRAME_FIRST   16'h0000
`define FRAME_LAST    16'h00FF
`define MODE_JTAG     4'h5
`define MODE_SLAVE    4'h7
`define MODE_MASTER   4'h0
`define MODE_ASYNC    4'h3

`endif

// ### logic/cfg_pins_pkg.sv
/*
 Types shared by the configuration pin controller files.
 Assumes the defines header is on the include path.
*/
`include "cfg_pins_defs.svh"
package cfg_pins_pkg;
	typedef logic [`MODE_W-1:0] mode_t;
	typedef enum logic [2:0] {
		ST_CLEAR  = 3'h0,
		ST_WAIT   = 3'h1,
		ST_CONFIG = 3'h2,
		ST_USER   = 3'h3
	} cfg_state_t;
endpackage

// ### logic/sync2.sv
/*
 Two flip-flop synchroniser for one level.
 Assumes an asynchronous input and the shared clock and reset.
*/
`timescale 1ns/1ps
module sync2 #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic meta_reg;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			meta_reg <= RST_VAL;
			q_o      <= RST_VAL;
		end else begin
			meta_reg <= d_i;
			q_o      <= meta_reg;
		end
	end
endmodule

// ### logic/config_control_pins.sv
/*
 Dedicated configuration pin controller: done, restart, readback and tristate
 control, error/interrupt output, mode capture, release of shared pins.
 Assumes the loader core reports progress on plain same-clock inputs and that
 all pin inputs are asynchronous and pass through sync2.
*/
// Behaviour
// - done released high only after configuration
// - restart input restarts config, resets scan
// - readback input low tristates io during config
// - after config tristate kept only if selected
// - readback falling edge reads from frame zero
// - serial output carries readback or scan data
// - error output low on memory init failure during config in jtag, slave, master or async mode only
// - same output is host port interrupt
// - mode pins latched at init rising edge
// - mode pins become user io after config
// - pll pins tristated, unused released after
// - init held low while clearing, wait externally
`timescale 1ns/1ps
`include "cfg_pins_defs.svh"
module config_control_pins
	import cfg_pins_pkg::*;
(
	input  wire logic                     clk_i,
	input  wire logic                     rstn_i,
	input  wire logic                     program_restart_n_i,
	input  wire logic                     rd_cfg_n_i,
	input  wire logic                     init_n_i,
	input  wire logic [`MODE_W-1:0]       mode_pins_i,
	input  wire logic                     cfg_finished_i,
	input  wire logic                     init_fail_i,
	input  wire logic                     host_port_used_i,
	input  wire logic                     host_port_irq_i,
	input  wire logic                     opt_tristate_i,
	input  wire logic                     opt_readback_i,
	input  wire logic                     scan_used_i,
	input  wire logic                     tdo_i,
	input  wire logic                     readback_bit_i,
	input  wire logic [`PLL_PINS-1:0]     pll_used_i,
	output logic                          done_oe_o,
	output logic                          init_oe_o,
	output logic                          global_tristate_o,
	output logic                          readback_start_o,
	output logic                          readback_busy_o,
	output logic [`FRAME_W-1:0]           frame_addr_o,
	output logic                          serial_out_o,
	output logic                          host_port_irq_n_o,
	output cfg_pins_pkg::mode_t           mode_o,
	output logic                          mode_pins_user_o,
	output logic [`PLL_PINS-1:0]          pll_pin_user_o,
	output logic                          scan_reset_o,
	output logic                          cfg_restart_o
);
	import cfg_pins_pkg::*;

	logic               prog_s;
	logic               rdcfg_s;
	logic               init_s;
	logic [`MODE_W-1:0] mode_s;
	cfg_state_t         state_reg;
	cfg_state_t         state_next;
	logic [`CLEAR_W-1:0] clear_cnt_reg;
	logic               rdcfg_d_reg;
	logic               init_d_reg;
	logic               err_reg;

	sync2 #(.RST_VAL(1'b1)) u_prog (.clk_i(clk_i), .rstn_i(rstn_i),
		.d_i(program_restart_n_i), .q_o(prog_s));
	sync2 #(.RST_VAL(1'b1)) u_rdcfg (.clk_i(clk_i), .rstn_i(rstn_i),
		.d_i(rd_cfg_n_i), .q_o(rdcfg_s));
	sync2 #(.RST_VAL(1'b0)) u_init (.clk_i(clk_i), .rstn_i(rstn_i),
		.d_i(init_n_i), .q_o(init_s));
	genvar gi;
	generate
		for (gi = 0; gi < `MODE_W; gi++) begin : g_mode
			sync2 #(.RST_VAL(1'b1)) u_m (.clk_i(clk_i), .rstn_i(rstn_i),
				.d_i(mode_pins_i[gi]), .q_o(mode_s[gi]));
		end
	endgenerate

	wire restart     = !prog_s;
	wire clear_done  = (clear_cnt_reg == `CLEAR_CYCLES);
	wire init_rise   = init_s && !init_d_reg;
	wire rd_fall     = rdcfg_d_reg && !rdcfg_s;
	wire in_user     = (state_reg == ST_USER);
	wire in_cfg      = !in_user;
	wire rb_go       = in_user && opt_readback_i && rd_fall && !readback_busy_o;
	wire rb_last     = readback_busy_o && (frame_addr_o == `FRAME_LAST);
	wire err_mode    = (mode_o == `MODE_JTAG) || (mode_o == `MODE_SLAVE) ||
	                   (mode_o == `MODE_MASTER) || (mode_o == `MODE_ASYNC);
	wire err_set     = in_cfg && err_mode && init_fail_i;
	wire ts_next     = !rdcfg_s && (in_cfg || opt_tristate_i);
	wire irq_n_next  = host_port_used_i ? !host_port_irq_i : !err_reg;
	wire ser_next    = scan_used_i ? tdo_i : (readback_busy_o & readback_bit_i);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_CLEAR:  if (clear_done) state_next = ST_WAIT;
			ST_WAIT:   if (init_rise) state_next = ST_CONFIG;
			ST_CONFIG: if (cfg_finished_i) state_next = ST_USER;
			ST_USER:   state_next = ST_USER;
		endcase
		if (restart) state_next = ST_CLEAR;
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state_reg     <= ST_CLEAR;
			clear_cnt_reg <= '0;
			rdcfg_d_reg   <= 1'b1;
			init_d_reg    <= 1'b0;
		end else begin
			state_reg     <= state_next;
			rdcfg_d_reg   <= rdcfg_s;
			init_d_reg    <= init_s;
			if (restart || state_reg != ST_CLEAR)
				clear_cnt_reg <= '0;
			else if (!clear_done)
				clear_cnt_reg <= clear_cnt_reg + 1'b1;
		end
	end

	// mode latched once per pass; later pin wiggles must not change the mode
	always_ff @(posedge clk_i) begin
		if (!rstn_i)
			mode_o <= '0;
		else if (state_reg == ST_WAIT && init_rise)
			mode_o <= mode_s;
	end

	// error is sticky for the pass; a new failure beats the restart clear
	always_ff @(posedge clk_i) begin
		if (!rstn_i)
			err_reg <= 1'b0;
		else if (err_set)
			err_reg <= 1'b1;
		else if (restart)
			err_reg <= 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			readback_busy_o  <= 1'b0;
			readback_start_o <= 1'b0;
			frame_addr_o     <= `FRAME_FIRST;
		end else begin
			readback_start_o <= rb_go;
			if (restart || rb_last) begin
				readback_busy_o <= 1'b0;
				frame_addr_o    <= `FRAME_FIRST;
			end else if (rb_go) begin
				readback_busy_o <= 1'b1;
				frame_addr_o    <= `FRAME_FIRST;
			end else if (readback_busy_o)
				frame_addr_o <= frame_addr_o + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			done_oe_o         <= 1'b1;
			init_oe_o         <= 1'b1;
			global_tristate_o <= 1'b0;
			serial_out_o      <= 1'b0;
			host_port_irq_n_o <= 1'b1;
			mode_pins_user_o  <= 1'b0;
			pll_pin_user_o    <= '0;
			scan_reset_o      <= 1'b1;
			cfg_restart_o     <= 1'b1;
		end else begin
			done_oe_o         <= !(state_next == ST_USER);
			init_oe_o         <= (state_next == ST_CLEAR);
			global_tristate_o <= ts_next;
			serial_out_o      <= ser_next;
			host_port_irq_n_o <= irq_n_next;
			mode_pins_user_o  <= (state_next == ST_USER);
			pll_pin_user_o    <= (state_next == ST_USER) ? ~pll_used_i : '0;
			scan_reset_o      <= restart;
			cfg_restart_o     <= restart;
		end
	end

	// checks on the controller: done, restart, tristate, readback, serial out, error, mode hold, pin release, init wait
	chk_done_low_cfg: assert property (@(posedge clk_i) disable iff (!rstn_i)
		in_cfg |-> done_oe_o) else $error("done released during config");
	chk_restart_done: assert property (@(posedge clk_i) disable iff (!rstn_i)
		restart |=> done_oe_o && scan_reset_o) else $error("restart not seen");
	chk_ts_cfg: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(in_cfg && !rdcfg_s) |=> global_tristate_o) else $error("no tristate");
	chk_ts_opt: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(in_user && !restart && !opt_tristate_i) |=> !global_tristate_o)
		else $error("tristate without option");
	chk_rb_frame0: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(readback_busy_o) |-> frame_addr_o == `FRAME_FIRST)
		else $error("readback not at frame zero");
	chk_rb_need_opt: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!opt_readback_i |=> !$rose(readback_busy_o)) else $error("readback w/o option");
	chk_tdo_pass: assert property (@(posedge clk_i) disable iff (!rstn_i)
		scan_used_i |=> serial_out_o == $past(tdo_i)) else $error("tdo not passed");
	chk_err_irq: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(err_set && !host_port_used_i) |=> ##1 !host_port_irq_n_o)
		else $error("error not flagged");
	chk_mode_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(state_reg == ST_CONFIG) |=> $stable(mode_o)) else $error("mode moved");
	chk_user_pins: assert property (@(posedge clk_i) disable iff (!rstn_i)
		in_cfg && state_next != ST_USER |=> !mode_pins_user_o && pll_pin_user_o == '0)
		else $error("pins released early");
	chk_init_wait: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(state_reg == ST_WAIT && !init_s && !restart) |=> state_reg == ST_WAIT)
		else $error("left wait while init low");

	cov_config_done: cover property (@(posedge clk_i) disable iff (!rstn_i)
		$fell(done_oe_o));
	cov_readback: cover property (@(posedge clk_i) disable iff (!rstn_i) rb_last);
	cov_error: cover property (@(posedge clk_i) disable iff (!rstn_i) err_set);
	cov_restart_user: cover property (@(posedge clk_i) disable iff (!rstn_i)
		in_user && restart);
endmodule

// ### dv/cfg_host_model.sv
/*
 Board side of the configuration pins: init open drain, readback pin, mode pins.
 Assumes the bench requests actions on plain inputs in the shared clock domain.
*/
`timescale 1ns/1ps
module cfg_host_model (
	input  wire logic       clk_i,
	input  wire logic       init_oe_i,
	input  wire logic       hold_init_i,
	input  wire logic       rd_low_i,
	input  wire logic       pins_user_i,
	input  wire logic [3:0] mode_i,
	output logic            init_n_o,
	output logic            rd_cfg_n_o,
	output logic [3:0]      mode_pins_o
);
	// pull-up wire, low while either side pulls
	assign init_n_o = !(init_oe_i | hold_init_i);
	// readback pin kept high until init is released
	assign rd_cfg_n_o = init_n_o ? !rd_low_i : 1'b1;
	// released pins toggle so a stale value never passes
	always_ff @(posedge clk_i) begin
		mode_pins_o <= pins_user_i ? ~mode_pins_o : mode_i;
	end
endmodule

// ### dv/tb_top.sv
/*
 Bench for the configuration pin controller with a board model on the pins.
 Assumes the defines header on the include path.
*/
`timescale 1ns/1ps
`include "cfg_pins_defs.svh"
module tb_top;
	import cfg_pins_pkg::*;
	logic clk_i, rstn_i, program_restart_n_i, cfg_finished_i, init_fail_i;
	logic host_port_used_i, host_port_irq_i, opt_tristate_i, opt_readback_i;
	logic scan_used_i, tdo_i, readback_bit_i, hold, rd_low, init_n_i, rd_cfg_n_i;
	logic [3:0] mode_req;
	logic [3:0] mode_pins_i;
	logic [`PLL_PINS-1:0] pll_used_i;
	logic [`PLL_PINS-1:0] pll_pin_user_o;
	logic [`FRAME_W-1:0] frame_addr_o;
	logic done_oe_o, init_oe_o, global_tristate_o, readback_start_o, readback_busy_o;
	logic serial_out_o, host_port_irq_n_o, mode_pins_user_o, scan_reset_o, cfg_restart_o;
	mode_t mode_o;
	mode_t mode_q[$];
	logic exp_irq_n;
	int mismatches, cmp_count, seed, k, n;
	mode_t codes [4] = '{`MODE_JTAG, `MODE_SLAVE, `MODE_MASTER, `MODE_ASYNC};

	config_control_pins config_control_pins_inst (.*);
	cfg_host_model cfg_host_model_inst (.clk_i, .init_oe_i(init_oe_o), .hold_init_i(hold),
		.rd_low_i(rd_low), .pins_user_i(mode_pins_user_o), .mode_i(mode_req),
		.init_n_o(init_n_i), .rd_cfg_n_o(rd_cfg_n_i), .mode_pins_o(mode_pins_i));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// drives land on rising edges, samples on falling ones
	task automatic at(input int c);
		repeat (c) @(posedge clk_i);
	endtask

	task automatic look;
		@(negedge clk_i);
	endtask

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	initial begin
		seed = 32'h72A18930;
		{rstn_i, cfg_finished_i, init_fail_i, host_port_used_i, host_port_irq_i} = '0;
		{opt_tristate_i, opt_readback_i, scan_used_i, tdo_i, readback_bit_i, rd_low} = '0;
		{program_restart_n_i, hold} = 2'h3;
		mode_req = 4'h0;
		pll_used_i = 16'($random(seed));
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'b1;
		// four error modes, then one random mode with readback
		for (k = 0; k < 5; k++) begin
			mode_q.push_back((k < 4) ? codes[k] : 4'($random(seed)));
			mode_req <= mode_q[$];
			at(30);
			look;
			check(init_oe_o, 1'b0);
			check(done_oe_o, 1'b1);
			check(pll_pin_user_o, 16'h0);
			at(1);
			hold <= 1'b0;
			at(6);
			look;
			check(mode_o, mode_q[0]);
			check(mode_pins_user_o, 1'b0);
			at(1);
			rd_low <= 1'b1;
			// pins move after the latch; the latched mode must not follow them
			mode_req <= ~mode_q[0];
			at(5);
			look;
			check(global_tristate_o, 1'b1);
			check(mode_o, mode_q[0]);
			at(1);
			rd_low <= 1'b0;
			init_fail_i <= 1'b1;
			at(1);
			init_fail_i <= 1'b0;
			at(2);
			look;
			exp_irq_n = !(mode_q[0] inside {`MODE_JTAG, `MODE_SLAVE,
				`MODE_MASTER, `MODE_ASYNC});
			check(host_port_irq_n_o, exp_irq_n);
			if (k < 4) begin
				at(1);
				host_port_used_i <= 1'b1;
				host_port_irq_i <= 1'b1;
				at(2);
				look;
				check(host_port_irq_n_o, 1'b0);
				at(1);
				host_port_irq_i <= 1'b0;
				at(2);
				look;
				check(host_port_irq_n_o, 1'b1);
				at(1);
				host_port_used_i <= 1'b0;
			end
			at(1);
			cfg_finished_i <= 1'b1;
			at(1);
			cfg_finished_i <= 1'b0;
			at(2);
			look;
			check(done_oe_o, 1'b0);
			check(mode_pins_user_o, 1'b1);
			check(pll_pin_user_o, ~pll_used_i);
			if (k == 4) begin
				at(1);
				rd_low <= 1'b1;
				at(4);
				look;
				check(global_tristate_o, 1'b0);
				check(readback_busy_o, 1'b0);
				at(1);
				opt_tristate_i <= 1'b1;
				at(2);
				look;
				check(global_tristate_o, 1'b1);
				at(1);
				{rd_low, opt_tristate_i, opt_readback_i, readback_bit_i} <= 4'h3;
				at(4);
				rd_low <= 1'b1;
				for (n = 0; n < 20 && readback_start_o !== 1'b1; n++) look;
				// a missing start counts here; the frame count check fails as well
				if (n == 20)
					mismatches++;
				// integer frame model: one frame per cycle from the first
				for (n = 0; readback_busy_o === 1'b1 && n < 300; n++) begin
					check(frame_addr_o, 16'(`FRAME_FIRST + n));
					if (n == 100) check(serial_out_o, 1'b1);
					if (n == 1) check(readback_start_o, 1'b0);
					look;
				end
				check(16'(n), 16'(`FRAME_LAST - `FRAME_FIRST + 1));
				at(1);
				// tdo high, readback idle low: only the scan path can give a one
				{scan_used_i, tdo_i} <= 2'h3;
				at(3);
				look;
				check(serial_out_o, 1'b1);
			end
			at(1);
			{program_restart_n_i, hold, rd_low} <= 3'h2;
			at(4);
			look;
			check(done_oe_o, 1'b1);
			check(scan_reset_o, 1'b1);
			check(cfg_restart_o, 1'b1);
			at(1);
			program_restart_n_i <= 1'b1;
			mode_q.delete(0);
		end
		test_done;
	end
endmodule
